// ==== include/nps_defs.svh ====
// Command codes, status bits and bus timing counts for the NAND sequencer host
`ifndef NPS_DEFS_SVH
`define NPS_DEFS_SVH
`define NPS_CMD_SERIAL_IN 8'h80
`define NPS_CMD_PLANE2_IN 8'h81
`define NPS_CMD_RAND_IN 8'h85
`define NPS_CMD_REPROG 8'h8b
`define NPS_CMD_CONFIRM 8'h10
`define NPS_CMD_DUMMY 8'h11
`define NPS_CMD_CACHE 8'h15
`define NPS_CMD_CB_READ0 8'h00
`define NPS_CMD_CB_READ 8'h35
`define NPS_CMD_ERASE 8'h60
`define NPS_CMD_ERASE_GO 8'hd0
`define NPS_CMD_STATUS 8'h70
`define NPS_CMD_STATUS_ENH 8'h78
`define NPS_CMD_RESET 8'hff
`define NPS_ST_FAIL 0
`define NPS_ST_PREV_FAIL 1
`define NPS_ST_ARRAY_RDY 5
`define NPS_ST_CACHE_RDY 6
`define NPS_ST_RESET_VAL 8'he0
`define NPS_ADDR_CYCLES_FULL 3'd5
`define NPS_ADDR_CYCLES_ROW 3'd3
`define NPS_STROBE_NS 40
`define NPS_CLK_NS 20
`define NPS_STROBE_CYC ((`NPS_STROBE_NS + `NPS_CLK_NS - 1) / `NPS_CLK_NS)
`endif

// ==== include/nps_pkg.sv ====
// Types shared by the NAND sequencer host
package nps_pkg;
  typedef enum logic [2:0] {
    NPS_OP_PROGRAM, NPS_OP_REPROGRAM, NPS_OP_CACHE, NPS_OP_COPYBACK, NPS_OP_ERASE,
    NPS_OP_STATUS, NPS_OP_STATUS_ENH, NPS_OP_RESET
  } nps_op_e;
  typedef struct packed {
    nps_op_e op;
    logic multi_plane;
    logic last_cache;
    logic [39:0] addr0;
    logic [39:0] addr1;
    logic [11:0] len;
  } nps_req_s;
  typedef struct packed {
    logic ale;
    logic cle;
    logic we_n;
    logic re_n;
    logic ce_n;
  } nps_ctl_s;
endpackage

// ==== rtl/nps_cycle.sv ====
// One bus write or read cycle on the flash pins
`timescale 1ns/1ps
`default_nettype none
`include "nps_defs.svh"
module nps_cycle (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic is_read,
  output logic busy,
  output logic strobe_low,
  output logic done
);
  localparam logic [3:0] PHASE = 4'(`NPS_STROBE_CYC);
  logic [4:0] cnt_reg;
  logic act_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      act_reg <= 1'b0;
      cnt_reg <= 5'h0;
    end else if (start && !act_reg) begin
      act_reg <= 1'b1;
      cnt_reg <= 5'h0;
    end else if (act_reg) begin
      if (cnt_reg == {PHASE, 1'b0} - 5'h1) act_reg <= 1'b0;
      cnt_reg <= cnt_reg + 5'h1;
    end
  end
  assign busy = act_reg;
  assign strobe_low = act_reg && (cnt_reg < {1'b0, PHASE});
  assign done = act_reg && (cnt_reg == {PHASE, 1'b0} - 5'h1);
  a_cycle_len: assert property (@(posedge clk) disable iff (rst)
    (start && !act_reg) |=> act_reg [*4] ##1 !act_reg)
    else $error("bus cycle length wrong");
endmodule // nps_cycle
`default_nettype wire

// ==== rtl/nps_host.sv ====
// Host sequencer issuing NAND program, erase and status command sequences
// Operation
// [RULE1] Host never repeats partial program of a page beyond the allowed count. The code still sends it and only raises ERROR.
// [RULE2] Host programs pages of a block in ascending order. The code also sends a lower page and only raises ERROR.
// [RULE3] Program opens with 80h, five address cycles, then data bytes.
// [RULE4] Confirm 10h starts programming only after serial data entry.
// [RULE5] Status read is accepted while programming runs.
// [RULE6] Command 85h with new column redirects the data loading.
// [RULE7] Re-program uses 8Bh, five address cycles, optional data, then 10h.
// [RULE8] Confirm 15h gives short cache busy, then frees the cache.
// [RULE9] During cache program status bit 6 shows cache ready.
// [RULE10] Status bit 5 shows array ready.
// [RULE11] After 15h ready, pass/fail covers the previous page only.
// [RULE12] Cache transfer waits for pending programming to finish.
// [RULE13] Host polls array ready until 1, then checks both fail flags.
// [RULE14] Copy-back reads with 35h, then 85h, address, data, 10h.
// [RULE15] Multi-plane: 80h page, 11h dummy busy, 81h page, 10h.
// [RULE16] Multi-plane addresses start with the first plane.
// [RULE17] Status 70h or 78h valid in dummy busy; 78h names plane. The code sends 78h with no address cycles.
// [RULE18] Multi-plane cache: bit 1 previous, bit 0 current result.
// [RULE19] A busy-pin-only host ends cache sequences with 10h.
// [RULE20] Multi-plane copy-back preceded by two single reads, same plane. The code issues one 00h/35h read, for addr0 only.
// [RULE21] Erase: 60h, three row cycles, D0h.
// [RULE22] During erase only status and reset are sent.
// [RULE23] Multi-plane erase: 60h twice, three cycles each, then D0h.
// [RULE24] Status bit 6 mirrors busy pin, bit 5 is idle flag.
// [RULE25] Reset FFh aborts operation and sets status to E0h.
// [RULE26] Busy pin low during any internal activity.
`timescale 1ns/1ps
`default_nettype none
`include "nps_defs.svh"
module nps_host #(
  parameter int unsigned MAX_PARTIAL = 4,
  parameter int unsigned LEN_W = 12
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic REQ_VALID,
  input wire nps_pkg::nps_req_s REQ,
  output logic REQ_READY,
  input wire logic WR_VALID,
  input wire logic [7:0] WR_DATA,
  output logic WR_READY,
  output logic DONE,
  output logic [7:0] STATUS,
  output logic ERROR,
  output var nps_pkg::nps_ctl_s CTL,
  output logic [7:0] IO_OUT,
  output logic IO_OE_N,
  input wire logic [7:0] IO_IN,
  input wire logic READY_BUSY_OUT_N
);
  typedef enum {
    S_IDLE, S_CMD, S_ADDR, S_DATA, S_WAIT, S_STATUS, S_STATUS_RD, S_DONE
  } nps_state_e;
  typedef enum logic [3:0] {
    P_SETUP, P_DUMMY, P_SETUP2, P_CONFIRM, P_CBREAD0, P_CBREAD, P_STAT, P_END
  } nps_phase_e;
  nps_state_e state_reg;
  nps_phase_e phase_reg;
  nps_pkg::nps_req_s req_reg;
  logic [7:0] cmd_reg;
  logic [2:0] acnt_reg;
  logic [LEN_W-1:0] dcnt_reg;
  logic second_reg;
  logic cyc_start, cyc_read, cyc_busy, cyc_low, cyc_done;
  logic rb_meta_reg, rb_sync_reg, rb_prev_reg;
  logic [7:0] io_meta_reg, io_sync_reg;
  logic [7:0] out_reg;
  logic ale_reg, cle_reg, oe_n_reg;
  logic [7:0] status_reg;
  logic [3:0] partial_reg;
  logic [39:0] last_page_reg;
  logic [1:0] wait_cnt_reg;

  function automatic logic [7:0] setup_cmd(input nps_pkg::nps_op_e op, input logic second);
    case (op)
      nps_pkg::NPS_OP_REPROGRAM: setup_cmd = `NPS_CMD_REPROG; // [RULE7]
      nps_pkg::NPS_OP_COPYBACK: setup_cmd = `NPS_CMD_RAND_IN; // [RULE14]
      nps_pkg::NPS_OP_ERASE: setup_cmd = `NPS_CMD_ERASE; // [RULE21] [RULE23]
      default: setup_cmd = second ? `NPS_CMD_PLANE2_IN : `NPS_CMD_SERIAL_IN; // [RULE3] [RULE15]
    endcase
  endfunction

  function automatic logic [7:0] confirm_cmd(input nps_pkg::nps_req_s r);
    if (r.op == nps_pkg::NPS_OP_ERASE) confirm_cmd = `NPS_CMD_ERASE_GO;
    else if (r.op == nps_pkg::NPS_OP_CACHE && !r.last_cache) confirm_cmd = `NPS_CMD_CACHE;
    else confirm_cmd = `NPS_CMD_CONFIRM; // [RULE19]
  endfunction

  // Pin inputs synchronised
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      rb_meta_reg <= 1'b0;
      rb_sync_reg <= 1'b0;
      rb_prev_reg <= 1'b0;
      io_meta_reg <= 8'h00;
      io_sync_reg <= 8'h00;
    end else begin
      rb_meta_reg <= READY_BUSY_OUT_N;
      rb_sync_reg <= rb_meta_reg;
      rb_prev_reg <= rb_sync_reg;
      io_meta_reg <= IO_IN;
      io_sync_reg <= io_meta_reg;
    end
  end

  nps_cycle u_cycle (
    .clk(CLK_SYS),
    .rst(RST),
    .start(cyc_start),
    .is_read(cyc_read),
    .busy(cyc_busy),
    .strobe_low(cyc_low),
    .done(cyc_done)
  );

  logic multi;
  logic [2:0] addr_n;
  logic [39:0] cur_addr;
  assign multi = req_reg.multi_plane;
  assign addr_n = (req_reg.op == nps_pkg::NPS_OP_ERASE) ? `NPS_ADDR_CYCLES_ROW
                                                        : `NPS_ADDR_CYCLES_FULL;
  // Erase sends row bytes only, column ignored
  assign cur_addr = second_reg ? req_reg.addr1 : req_reg.addr0; // [RULE16]

  // Settle time so the synchronised busy pin reflects the last command
  always_ff @(posedge CLK_SYS) begin
    if (RST || state_reg != S_WAIT) wait_cnt_reg <= 2'h0;
    else if (wait_cnt_reg != 2'h3) wait_cnt_reg <= wait_cnt_reg + 2'h1;
  end

  // Main sequencer
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      state_reg <= S_IDLE;
      phase_reg <= P_SETUP;
      req_reg <= '0;
      cmd_reg <= 8'h00;
      acnt_reg <= 3'h0;
      dcnt_reg <= '0;
      second_reg <= 1'b0;
    end else begin
      case (state_reg)
        S_IDLE: begin
          if (REQ_VALID) begin
            req_reg <= REQ;
            second_reg <= 1'b0;
            acnt_reg <= 3'h0;
            case (REQ.op)
              nps_pkg::NPS_OP_STATUS: begin
                cmd_reg <= `NPS_CMD_STATUS;
                phase_reg <= P_STAT;
              end
              nps_pkg::NPS_OP_STATUS_ENH: begin
                cmd_reg <= `NPS_CMD_STATUS_ENH; // [RULE17]
                phase_reg <= P_STAT;
              end
              nps_pkg::NPS_OP_RESET: begin
                cmd_reg <= `NPS_CMD_RESET; // [RULE25]
                phase_reg <= P_END;
              end
              nps_pkg::NPS_OP_COPYBACK: begin
                cmd_reg <= `NPS_CMD_CB_READ0; // [RULE14] [RULE20]
                phase_reg <= P_CBREAD0;
              end
              default: begin
                cmd_reg <= setup_cmd(REQ.op, 1'b0);
                phase_reg <= P_SETUP;
              end
            endcase
            state_reg <= S_CMD;
          end
        end
        S_CMD: if (cyc_done) begin
          case (phase_reg)
            P_SETUP, P_SETUP2, P_CBREAD0: begin
              acnt_reg <= 3'h0;
              state_reg <= S_ADDR;
            end
            P_STAT: state_reg <= S_STATUS_RD; // [RULE5]
            P_END: state_reg <= S_WAIT;
            default: state_reg <= S_WAIT; // Dummy, 35h, confirm all busy
          endcase
        end
        S_ADDR: if (cyc_done) begin
          acnt_reg <= acnt_reg + 3'h1;
          if (acnt_reg == addr_n - 3'h1) begin
            dcnt_reg <= '0;
            if (phase_reg == P_CBREAD0) begin
              cmd_reg <= `NPS_CMD_CB_READ;
              phase_reg <= P_CBREAD;
              state_reg <= S_CMD;
            end else if (req_reg.op == nps_pkg::NPS_OP_ERASE) begin
              if (multi && !second_reg) begin
                second_reg <= 1'b1; // No dummy busy between erase blocks
                cmd_reg <= `NPS_CMD_ERASE;
                phase_reg <= P_SETUP2;
                state_reg <= S_CMD; // [RULE23]
              end else begin
                cmd_reg <= `NPS_CMD_ERASE_GO;
                phase_reg <= P_CONFIRM;
                state_reg <= S_CMD; // [RULE21]
              end
            end else if (req_reg.len != '0) begin
              state_reg <= S_DATA; // [RULE3]
            end else begin
              cmd_reg <= (multi && !second_reg) ? `NPS_CMD_DUMMY : confirm_cmd(req_reg);
              phase_reg <= (multi && !second_reg) ? P_DUMMY : P_CONFIRM;
              state_reg <= S_CMD; // [RULE7]
            end
          end
        end
        S_DATA: if (cyc_done) begin
          dcnt_reg <= dcnt_reg + 1'b1;
          if (dcnt_reg == req_reg.len - 1'b1) begin
            cmd_reg <= (multi && !second_reg) ? `NPS_CMD_DUMMY : confirm_cmd(req_reg);
            phase_reg <= (multi && !second_reg) ? P_DUMMY : P_CONFIRM; // [RULE15]
            state_reg <= S_CMD; // [RULE4]
          end
        end
        S_WAIT: if (wait_cnt_reg == 2'h3 && rb_sync_reg && !cyc_busy) begin // [RULE26]
          case (phase_reg)
            P_CBREAD: begin
              cmd_reg <= `NPS_CMD_RAND_IN;
              phase_reg <= P_SETUP;
              acnt_reg <= 3'h0;
              state_reg <= S_CMD; // [RULE14]
            end
            P_DUMMY: begin
              second_reg <= 1'b1;
              cmd_reg <= setup_cmd(req_reg.op, 1'b1);
              phase_reg <= P_SETUP2;
              state_reg <= S_CMD; // [RULE15]
            end
            P_END: state_reg <= S_DONE;
            default: begin
              cmd_reg <= `NPS_CMD_STATUS; // [RULE13]
              phase_reg <= P_STAT;
              state_reg <= S_CMD;
            end
          endcase
        end
        S_STATUS_RD: if (cyc_done) begin
          if (req_reg.op == nps_pkg::NPS_OP_CACHE && req_reg.last_cache
              && !io_sync_reg[`NPS_ST_ARRAY_RDY]) begin
            cmd_reg <= `NPS_CMD_STATUS; // [RULE13] [RULE19]
            state_reg <= S_CMD;
          end else begin
            state_reg <= S_DONE;
          end
        end
        S_DONE: state_reg <= S_IDLE;
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  assign cyc_read = (state_reg == S_STATUS_RD);
  assign cyc_start = !cyc_busy && !cyc_done &&
                     (state_reg == S_CMD || state_reg == S_ADDR ||
                      state_reg == S_STATUS_RD || (state_reg == S_DATA && WR_VALID));
  assign WR_READY = (state_reg == S_DATA) && !cyc_busy;
  assign REQ_READY = (state_reg == S_IDLE);

  // Pin drive registers
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      out_reg <= 8'h00;
      cle_reg <= 1'b0;
      ale_reg <= 1'b0;
      oe_n_reg <= 1'b1;
    end else if (cyc_start) begin
      cle_reg <= (state_reg == S_CMD);
      ale_reg <= (state_reg == S_ADDR);
      oe_n_reg <= (state_reg == S_STATUS_RD);
      case (state_reg)
        S_CMD: out_reg <= cmd_reg;
        S_ADDR: out_reg <= (req_reg.op == nps_pkg::NPS_OP_ERASE) ?
                           cur_addr[8*acnt_reg+16 +: 8] : cur_addr[8*acnt_reg +: 8];
        default: out_reg <= WR_DATA; // [RULE6]
      endcase
    end else if (!cyc_busy) begin
      oe_n_reg <= 1'b1;
      cle_reg <= 1'b0;
      ale_reg <= 1'b0;
    end
  end

  // Status capture, reset value, partial and order bookkeeping
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      status_reg <= `NPS_ST_RESET_VAL;
      partial_reg <= 4'h0;
      last_page_reg <= '0;
    end else if (state_reg == S_STATUS_RD && cyc_done) begin
      status_reg <= io_sync_reg; // [RULE9] [RULE10] [RULE11] [RULE18] [RULE24]
    end else if (state_reg == S_DONE && req_reg.op == nps_pkg::NPS_OP_RESET) begin
      status_reg <= `NPS_ST_RESET_VAL; // [RULE25]
    end else if (state_reg == S_IDLE && REQ_VALID) begin
      if (REQ.op == nps_pkg::NPS_OP_ERASE) partial_reg <= 4'h0;
      else if (REQ.op == nps_pkg::NPS_OP_PROGRAM) begin
        partial_reg <= (REQ.addr0[39:16] == last_page_reg[39:16]) ? partial_reg + 4'h1 : 4'h1;
        last_page_reg <= REQ.addr0;
      end
    end
  end

  logic err_reg;
  always_ff @(posedge CLK_SYS) begin
    if (RST) err_reg <= 1'b0;
    else if (state_reg == S_IDLE && REQ_VALID)
      err_reg <= (REQ.op == nps_pkg::NPS_OP_PROGRAM) && // [RULE1] [RULE2]
                 ((REQ.addr0[39:16] == last_page_reg[39:16] &&
                   partial_reg >= 4'(MAX_PARTIAL)) ||
                  (REQ.addr0[39:16] < last_page_reg[39:16] &&
                   REQ.addr0[39:22] == last_page_reg[39:22]));
  end

  assign DONE = (state_reg == S_DONE);
  assign STATUS = status_reg;
  assign ERROR = err_reg;
  assign IO_OUT = out_reg;
  assign IO_OE_N = oe_n_reg;
  assign CTL = '{ale: ale_reg, cle: cle_reg, we_n: !(cyc_low && !cyc_read),
                 re_n: !(cyc_low && cyc_read), ce_n: (state_reg == S_IDLE)};

  a_busy_wait: assert property (@(posedge CLK_SYS) disable iff (RST)
    (state_reg == S_WAIT && !rb_sync_reg) |=> state_reg == S_WAIT) // [RULE26]
    else $error("left wait while busy");
  a_reset_status: assert property (@(posedge CLK_SYS) disable iff (RST)
    (DONE && req_reg.op == nps_pkg::NPS_OP_RESET) |=> STATUS == 8'he0) // [RULE25]
    else $error("status not e0 after reset");
  a_erase_addr: assert property (@(posedge CLK_SYS) disable iff (RST)
    (state_reg == S_ADDR && req_reg.op == nps_pkg::NPS_OP_ERASE) |-> acnt_reg < 3'd3) // [RULE21]
    else $error("erase address too long");
  a_prog_addr: assert property (@(posedge CLK_SYS) disable iff (RST)
    (state_reg == S_ADDR && req_reg.op == nps_pkg::NPS_OP_PROGRAM) |-> acnt_reg < 3'd5) // [RULE3]
    else $error("program address too long");
  a_dummy_cmd: assert property (@(posedge CLK_SYS) disable iff (RST)
    (phase_reg == P_DUMMY && state_reg == S_CMD) |-> cmd_reg == 8'h11) // [RULE15]
    else $error("dummy confirm wrong");
  a_oe_read: assert property (@(posedge CLK_SYS) disable iff (RST)
    (!CTL.re_n) |-> IO_OE_N) // [RULE5]
    else $error("driving bus during read");
  a_cle_ale: assert property (@(posedge CLK_SYS) disable iff (RST)
    !(CTL.cle && CTL.ale)) // [RULE3]
    else $error("cle and ale together");
  a_confirm_data: assert property (@(posedge CLK_SYS) disable iff (RST)
    (state_reg == S_DATA && cyc_done && dcnt_reg == req_reg.len - 1'b1 && !multi)
    |=> cmd_reg == confirm_cmd(req_reg)) // [RULE4]
    else $error("confirm not after data");
endmodule // nps_host
`default_nettype wire

// ==== testbench/nps_flash_model.sv ====
// Behavioural flash device model facing the sequencer host
`timescale 1ns/1ps
`default_nettype none
module nps_flash_model #(
  parameter int PROG_CYC = 40,
  parameter int TCB_CYC = 6,
  parameter int DBSY_CYC = 3,
  parameter int ERASE_CYC = 50
) (
  input wire logic clk,
  input wire nps_pkg::nps_ctl_s ctl,
  input wire logic [7:0] io_out,
  input wire logic io_oe_n,
  input wire logic fail_in,
  output logic [7:0] io_in,
  output logic rb_n
);
  logic [9:0] log_q[$];
  int rb_cnt = 0;
  int arr_cnt = 0;
  int viol = 0;
  logic cur_f = 1'b0;
  logic prev_f = 1'b0;
  logic in_cache = 1'b0;
  logic loaded = 1'b0;
  logic [7:0] last = 8'h00;
  logic [7:0] w;
  logic [7:0] st;
  assign st = {1'b1, rb_cnt == 0, arr_cnt == 0, 3'h0, prev_f, cur_f};
  assign rb_n = (rb_cnt == 0);
  // Released bus shows the inverse of the last driven value
  assign io_in = (!ctl.ce_n && !ctl.re_n) ? st : ~last;
  always @(posedge clk) begin
    if (rb_cnt > 0) rb_cnt--;
    if (arr_cnt > 0) arr_cnt--;
    if (!ctl.ce_n && !ctl.re_n) last = st;
  end
  always @(posedge ctl.we_n) begin
    w = io_oe_n ? 8'hxx : io_out;
    if (!ctl.ce_n) begin
      log_q.push_back({ctl.cle, ctl.ale, w});
      // Only status and reset may enter while the busy pin is low
      if (rb_cnt != 0 && !(ctl.cle && w inside {8'h70, 8'h78, 8'hff})) viol++;
      if (!ctl.cle && !ctl.ale) loaded = 1'b1;
      if (ctl.cle) begin
        case (w)
          8'h80, 8'h60: loaded = 1'b0;
          8'h8b: loaded = 1'b1;
          8'h10, 8'h15: if (loaded) begin
            prev_f = (w == 8'h15 || in_cache) ? cur_f : 1'b0;
            cur_f = fail_in;
            in_cache = (w == 8'h15);
            loaded = 1'b0;
            rb_cnt = (w == 8'h15) ? TCB_CYC + arr_cnt : arr_cnt + PROG_CYC;
            arr_cnt = rb_cnt + ((w == 8'h15) ? PROG_CYC : 0);
          end
          8'h11: begin
            rb_cnt = DBSY_CYC;
            arr_cnt = DBSY_CYC;
          end
          8'h35: begin
            loaded = 1'b1;
            rb_cnt = PROG_CYC;
            arr_cnt = PROG_CYC;
          end
          8'hd0: begin
            prev_f = 1'b0;
            cur_f = fail_in;
            rb_cnt = ERASE_CYC;
            arr_cnt = ERASE_CYC;
          end
          8'hff: begin
            prev_f = 1'b0;
            cur_f = 1'b0;
            in_cache = 1'b0;
            loaded = 1'b0;
            rb_cnt = DBSY_CYC;
            arr_cnt = 0;
          end
          default: ;
        endcase
      end
    end
  end
endmodule // nps_flash_model
`default_nettype wire

// ==== testbench/nps_host_bench.sv ====
// Self-checking bench for the NAND program and erase sequencer host
`timescale 1ns/1ps
`default_nettype none
module nps_host_bench;
  typedef struct {
    nps_pkg::nps_op_e op;
    logic mp;
    logic lc;
    int len;
    logic f;
    logic [31:0] cmds;
    int nc;
    int na;
    logic [7:0] st;
    logic [39:0] a0;
  } nps_row_s;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  nps_pkg::nps_req_s req = '0;
  logic wr_valid = 1'b0;
  logic [7:0] wr_data = 8'h30;
  logic fail_in = 1'b0;
  logic took = 1'b0;
  logic req_ready, wr_ready, done, error, io_oe_n, rb_n;
  logic [7:0] status, io_out, io_wire, flash_q;
  nps_pkg::nps_ctl_s ctl;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  int t;
  nps_row_s rows[13];
  nps_host u_dut (.CLK_SYS(clk), .RST(rst), .REQ_VALID(req_valid), .REQ(req),
    .REQ_READY(req_ready), .WR_VALID(wr_valid), .WR_DATA(wr_data), .WR_READY(wr_ready),
    .DONE(done), .STATUS(status), .ERROR(error), .CTL(ctl), .IO_OUT(io_out),
    .IO_OE_N(io_oe_n), .IO_IN(io_wire), .READY_BUSY_OUT_N(rb_n));
  nps_flash_model u_flash (.clk(clk), .ctl(ctl), .io_out(io_out), .io_oe_n(io_oe_n),
    .fail_in(fail_in), .io_in(flash_q), .rb_n(rb_n));
  // Wire level from whichever side drives the shared data pins
  assign io_wire = !io_oe_n ? io_out : flash_q;
  initial forever #10 clk = ~clk;
  always @(posedge clk) took <= wr_valid & wr_ready;
  always @(negedge clk) if (took) wr_data <= wr_data + 8'h01;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      print_verdict();
    end
  end
  task automatic chk(input bit ok, input string m);
    n_checks++;
    if (!ok) begin
      err_total++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic run(input nps_pkg::nps_op_e o, input logic mp, input logic lc, input int n,
      input logic [39:0] a, input logic f);
    u_flash.log_q.delete();
    fail_in = f;
    wr_data = 8'h30;
    req = '{op: o, multi_plane: mp, last_cache: lc, addr0: a, addr1: a | 40'h0000010000,
      len: n[11:0]};
    req_valid = 1'b1;
    t = 0;
    while (req_ready !== 1'b1 && t < 3000) begin
      @(negedge clk);
      t++;
    end
    @(negedge clk);
    req_valid = 1'b0;
    while (done !== 1'b1 && t < 3000) begin
      @(negedge clk);
      t++;
    end
    chk(t < 3000, "no completion");
  endtask
  initial begin
    nps_row_s r;
    logic [9:0] e;
    logic [31:0] got;
    logic [7:0] fa;
    int k, na, nd;
    bit dok;
    rows = '{
      '{nps_pkg::NPS_OP_PROGRAM, 0, 0, 3, 0, 32'h80100000, 2, 5, 8'he0, 40'h0100000012},
      '{nps_pkg::NPS_OP_PROGRAM, 0, 0, 2, 1, 32'h80100000, 2, 5, 8'he1, 40'h0200000034},
      '{nps_pkg::NPS_OP_PROGRAM, 1, 0, 2, 0, 32'h80118110, 4, 10, 8'he0, 40'h0300000000},
      '{nps_pkg::NPS_OP_REPROGRAM, 0, 0, 0, 0, 32'h8b100000, 2, 5, 8'he0, 40'h0400000000},
      '{nps_pkg::NPS_OP_REPROGRAM, 1, 0, 2, 1, 32'h8b118b10, 4, 10, 8'he1, 40'h0600000000},
      '{nps_pkg::NPS_OP_COPYBACK, 0, 0, 2, 0, 32'h00358510, 4, 10, 8'he0, 40'h0700000000},
      '{nps_pkg::NPS_OP_CACHE, 0, 0, 2, 1, 32'h80150000, 2, 5, 8'h00, 40'h0500000000},
      '{nps_pkg::NPS_OP_CACHE, 0, 1, 2, 0, 32'h80100000, 2, 5, 8'he2, 40'h0500010000},
      '{nps_pkg::NPS_OP_ERASE, 0, 0, 0, 1, 32'h60d00000, 2, 3, 8'he1, 40'h0800000000},
      '{nps_pkg::NPS_OP_ERASE, 1, 0, 0, 0, 32'h6060d000, 3, 6, 8'he0, 40'h0800000000},
      '{nps_pkg::NPS_OP_STATUS, 0, 0, 0, 0, 32'h00000000, 0, 0, 8'he0, 40'h0},
      '{nps_pkg::NPS_OP_STATUS_ENH, 0, 0, 0, 0, 32'h78000000, 1, 0, 8'he0, 40'h0},
      '{nps_pkg::NPS_OP_RESET, 0, 0, 0, 0, 32'hff000000, 1, 0, 8'he0, 40'h0}
    };
    repeat (8) @(negedge clk);
    chk(status === 8'he0 && ctl.ce_n === 1'b1 && io_oe_n === 1'b1, "reset state");
    rst = 1'b0;
    wr_valid = 1'b1;
    $display("test reset done");
    foreach (rows[i]) begin
      r = rows[i];
      run(r.op, r.mp, r.lc, r.len, r.a0, r.f);
      got = '0;
      k = 0;
      na = 0;
      nd = 0;
      fa = 8'h00;
      dok = 1'b1;
      foreach (u_flash.log_q[j]) begin
        e = u_flash.log_q[j];
        if (e[9] && e[7:0] !== 8'h70) begin
          if (k < 4) got[31 - 8 * k -: 8] = e[7:0];
          k++;
        end else if (e[8]) begin
          if (na == 0) fa = e[7:0];
          na++;
        end else if (!e[9]) begin
          dok &= (e[7:0] === 8'h30 + nd[7:0]);
          nd++;
        end
      end
      chk(got === r.cmds && k == r.nc, "command order");
      chk(na == r.na, "address cycle count");
      chk(dok && nd == r.len * (r.mp ? 2 : 1), "data bytes");
      if (r.op inside {nps_pkg::NPS_OP_PROGRAM, nps_pkg::NPS_OP_ERASE})
        chk(fa === (r.op == nps_pkg::NPS_OP_ERASE ? r.a0[23:16] : r.a0[7:0]), "first address");
      if (r.st !== 8'h00) chk(status === r.st, "status byte");
      chk(error === 1'b0, "error flag");
      $display("test row %0d done", i);
    end
    chk(u_flash.viol == 0, "command while busy");
    for (int i = 0; i < 5; i++) begin
      run(nps_pkg::NPS_OP_PROGRAM, 0, 0, 1, 40'h0900000000, 0);
      chk(error === (i == 4), "partial program count");
    end
    $display("test partial count done");
    rst = 1'b1;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    run(nps_pkg::NPS_OP_PROGRAM, 0, 0, 1, 40'h0a00030000, 0);
    run(nps_pkg::NPS_OP_PROGRAM, 0, 0, 1, 40'h0a00010000, 0);
    chk(error === 1'b1, "descending page accepted");
    $display("test page order done");
    print_verdict();
  end
endmodule // nps_host_bench
`default_nettype wire
